// ### logic/uart_rx_pkg.sv
// Shared constants and types for the serial receiver with error flags
package uart_rx_pkg;

  // Register byte offsets
  localparam logic [4:0] data_offset    = 5'h00;
  localparam logic [4:0] status_offset  = 5'h04;
  localparam logic [4:0] control_offset = 5'h08;
  localparam logic [4:0] format_offset  = 5'h0c;
  localparam logic [4:0] divisor_offset = 5'h10;

  // Status field positions
  localparam int status_complete_bit = 7;
  localparam int status_fe_bit       = 4;
  localparam int status_dor_bit      = 3;
  localparam int status_pe_bit       = 2;

  // Control field positions
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_double_bit = 1;

  // Format field positions
  localparam int fmt_size_lsb  = 1;
  localparam int fmt_stop_bit  = 3;
  localparam int fmt_podd_bit  = 4;
  localparam int fmt_pon_bit   = 5;

  // Reset values
  localparam logic [7:0]  control_reset = 8'h00;
  localparam logic [7:0]  format_reset  = 8'h06;
  localparam logic [15:0] divisor_reset = 16'h0000;

  // Samples per bit and voting points
  localparam logic [4:0] samples_normal = 5'h10;
  localparam logic [4:0] samples_double = 5'h08;
  localparam logic [4:0] vote_first_normal = 5'h08;
  localparam logic [4:0] vote_mid_normal   = 5'h09;
  localparam logic [4:0] vote_last_normal  = 5'h0a;
  localparam logic [4:0] vote_first_double = 5'h04;
  localparam logic [4:0] vote_mid_double   = 5'h05;
  localparam logic [4:0] vote_last_double  = 5'h06;
  localparam logic [3:0] min_data_bits     = 4'h5;
  localparam logic [3:0] max_data_bits     = 4'h8;

  // Bus responses
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum logic [2:0]
  {
    st_idle  = 3'b001,
    st_start = 3'b010,
    st_bits  = 3'b100
  } rx_state_type;

endpackage

// ### logic/rx_sampler.sv
// Input synchroniser and sample tick divider
`timescale 1ns/1ps
module rx_sampler
  import uart_rx_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Line and rate
  input  wire logic        rxd,
  input  wire logic [15:0] divisor,
  // Results
  output logic             rxd_sync,
  output logic             tick
);

  logic        rxd_meta;
  logic [15:0] count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end
    else
    begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // Tick period is divisor plus one cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end
    else if (count == 16'h0000)
    begin
      count <= divisor;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count - 16'h0001;
      tick  <= 1'b0;
    end
  end

  chk_sync_two_stage : assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> rxd_sync == $past(rxd, 2))
    else $error("synchroniser depth is not two");

endmodule

// ### logic/rx_frame.sv
// Start detection and majority-vote bit recovery of one frame
`timescale 1ns/1ps
module rx_frame
  import uart_rx_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       receiver_on,
  input  wire logic       double_speed_select,
  input  wire logic       parity_check_on,
  input  wire logic       parity_odd_select,
  input  wire logic [1:0] char_size,
  // Samples
  input  wire logic       tick,
  input  wire logic       rxd_sync,
  // Frame results
  output logic            start_seen,
  output logic            frame_done,
  output logic [7:0]      frame_data,
  output logic            frame_fe,
  output logic            frame_pe
);

  rx_state_type state;
  logic [4:0]   samp;
  logic [3:0]   bitn;
  logic [7:0]   shreg;
  logic         v1;
  logic         v2;
  logic         line_high;
  logic         par_lat;
  logic         perr;
  logic [3:0]   nbits;
  logic [3:0]   shamt;
  logic [4:0]   s_top;
  logic [4:0]   s_first;
  logic [4:0]   s_mid;
  logic [4:0]   s_last;
  logic         vote;
  logic [7:0]   aligned;

  assign s_top   = double_speed_select ? samples_double : samples_normal;
  assign s_first = double_speed_select ? vote_first_double : vote_first_normal;
  assign s_mid   = double_speed_select ? vote_mid_double : vote_mid_normal;
  assign s_last  = double_speed_select ? vote_last_double : vote_last_normal;
  assign nbits   = min_data_bits + {2'b00, char_size};
  assign shamt   = max_data_bits - nbits;
  assign vote    = (v1 & v2) | (v1 & rxd_sync) | (v2 & rxd_sync);
  assign aligned = shreg >> shamt;

  // disable drops any frame in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !receiver_on)
    begin
      state      <= st_idle;
      samp       <= 5'h00;
      bitn       <= 4'h0;
      shreg      <= 8'h00;
      v1         <= 1'b0;
      v2         <= 1'b0;
      line_high  <= 1'b0;
      par_lat    <= 1'b0;
      perr       <= 1'b0;
      start_seen <= 1'b0;
      frame_done <= 1'b0;
      frame_data <= 8'h00;
      frame_fe   <= 1'b0;
      frame_pe   <= 1'b0;
    end
    else
    begin
      start_seen <= 1'b0;
      frame_done <= 1'b0;
      if (tick)
      begin
        if (state != st_idle)
        begin
          samp <= (samp == s_top) ? 5'h01 : samp + 5'h01;
          if (samp == s_first)
            v1 <= rxd_sync;
          if (samp == s_mid)
            v2 <= rxd_sync;
        end
        case (state)
          st_idle:
          begin
            line_high <= rxd_sync;
            // first low sample is sample one
            if (line_high && !rxd_sync)
            begin
              state <= st_start;
              samp  <= 5'h01;
            end
          end
          st_start:
          begin
            if (samp == s_last)
            begin
              // reject spike or go on to the data bits
              if (vote)
              begin
                state     <= st_idle;
                line_high <= 1'b0;
              end
              else
              begin
                state      <= st_bits;
                bitn       <= 4'h0;
                par_lat    <= parity_check_on;
                perr       <= 1'b0;
                start_seen <= 1'b1;
              end
            end
          end
          st_bits:
          begin
            if (samp == s_last)
            begin
              bitn <= bitn + 4'h1;
              if (bitn < nbits)
                shreg <= {vote, shreg[7:1]};
              else if (bitn == nbits && par_lat)
                perr <= ^aligned ^ vote ^ parity_odd_select;
              else
              begin
                // frame ends on first stop bit
                frame_done <= 1'b1;
                frame_data <= aligned;
                // stop bit low is a fault
                frame_fe   <= ~vote;
                frame_pe   <= par_lat & perr;
                state      <= st_idle;
                line_high  <= vote;
              end
            end
          end
          default:
            state <= st_idle;
        endcase
      end
    end
  end

  chk_start_reject : assert property (@(posedge aclk) disable iff (!aresetn)
    (receiver_on && tick && state == st_start && samp == s_last && vote) |=> state == st_idle)
    else $error("noisy start bit was not rejected");

  chk_done_to_idle : assert property (@(posedge aclk) disable iff (!aresetn)
    frame_done |-> state == st_idle)
    else $error("receiver not hunting after stop vote");

endmodule

// ### logic/uart_rx_core.sv
// Serial receiver: bus slave, two-entry buffer with per-frame error flags
`timescale 1ns/1ps
module uart_rx_core
  import uart_rx_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line
  input  wire logic        rxd,
  output logic             rx_pin_claim
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and wiring

  logic [7:0]  control;
  logic [7:0]  format;
  logic [15:0] divisor;
  logic        receiver_on;
  logic        double_speed_select;
  logic        parity_check_on;
  logic        parity_odd_select;
  logic        stop_bit_count_select;
  logic        rxd_sync;
  logic        tick;
  logic        start_seen;
  logic        frame_done;
  logic [7:0]  frame_data;
  logic        frame_fe;
  logic        frame_pe;

  assign receiver_on           = control[ctrl_enable_bit];
  assign double_speed_select   = control[ctrl_double_bit];
  assign parity_check_on       = format[fmt_pon_bit];
  assign parity_odd_select     = format[fmt_podd_bit];
  // Kept for software; receiver never looks past the first stop bit
  assign stop_bit_count_select = format[fmt_stop_bit];

  // pin handed back as soon as enable drops
  assign rx_pin_claim = receiver_on;

  rx_sampler u_sampler
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .rxd      (rxd),
    .divisor  (divisor),
    .rxd_sync (rxd_sync),
    .tick     (tick)
  );

  rx_frame u_frame
  (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .receiver_on         (receiver_on),
    .double_speed_select (double_speed_select),
    .parity_check_on     (parity_check_on),
    .parity_odd_select   (parity_odd_select),
    .char_size           (format[fmt_size_lsb +: 2]),
    .tick                (tick),
    .rxd_sync            (rxd_sync),
    .start_seen          (start_seen),
    .frame_done          (frame_done),
    .frame_data          (frame_data),
    .frame_fe            (frame_fe),
    .frame_pe            (frame_pe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shift-register hold stage and two-entry buffer

  logic       hold_valid;
  logic [7:0] hold_data;
  logic       hold_fe;
  logic       hold_pe;
  logic       ovr_pending;
  logic [1:0] count;
  logic       wr_ptr;
  logic       rd_ptr;
  logic       push;
  logic       pop;
  logic [7:0] buf_data [2];
  logic       buf_fe   [2];
  logic       buf_pe   [2];
  logic       buf_dor  [2];

  assign push = hold_valid && (count != 2'd2);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !receiver_on)
    begin
      hold_valid <= 1'b0;
      hold_data  <= 8'h00;
      hold_fe    <= 1'b0;
      hold_pe    <= 1'b0;
    end
    // new frame dropped while hold is occupied and the buffer is full
    else if (frame_done && (!hold_valid || push))
    begin
      hold_valid <= 1'b1;
      hold_data  <= frame_data;
      hold_fe    <= frame_fe;
      hold_pe    <= frame_pe;
    end
    else if (push)
      hold_valid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !receiver_on)
      ovr_pending <= 1'b0;
    // full buffer, busy hold, fresh start
    else if (start_seen && count == 2'd2 && hold_valid)
      ovr_pending <= 1'b1;
    else if (push)
      ovr_pending <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !receiver_on)
    begin
      count  <= 2'd0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'd1;
      else if (pop && !push)
        count <= count - 2'd1;
    end
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_entry
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        buf_data[i] <= 8'h00;
        buf_fe[i]   <= 1'b0;
        buf_pe[i]   <= 1'b0;
        buf_dor[i]  <= 1'b0;
      end
      else if (push && wr_ptr == 1'(i))
      begin
        buf_data[i] <= hold_data;
        buf_fe[i]   <= hold_fe;
        buf_pe[i]   <= hold_pe;
        buf_dor[i]  <= ovr_pending;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status view of the next unread frame

  logic       rx_complete_flag;
  logic       stop_bit_fault_flag;
  logic       rx_overflow_flag;
  logic       parity_fault_flag;
  logic [7:0] status_view;

  assign rx_complete_flag    = (count != 2'd0);
  assign stop_bit_fault_flag = rx_complete_flag & buf_fe[rd_ptr];
  assign rx_overflow_flag    = rx_complete_flag & buf_dor[rd_ptr];
  // forced low while checking is off
  assign parity_fault_flag   = rx_complete_flag & buf_pe[rd_ptr] & parity_check_on;

  // flags feed no interrupt, status only
  always_comb
  begin
    status_view                      = 8'h00;
    status_view[status_complete_bit] = rx_complete_flag;
    status_view[status_fe_bit]       = stop_bit_fault_flag;
    status_view[status_dor_bit]      = rx_overflow_flag;
    status_view[status_pe_bit]       = parity_fault_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path

  logic       aw_held;
  logic       w_held;
  logic [4:0] aw_addr;
  logic [7:0] w_low;
  logic [7:0] w_high;
  logic [1:0] w_lanes;
  logic       do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 5'h00;
      w_low   <= 8'h00;
      w_high  <= 8'h00;
      w_lanes <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        w_low   <= s_axi_wdata[7:0];
        w_high  <= s_axi_wdata[15:8];
        w_lanes <= s_axi_wstrb[1:0];
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        data_offset, status_offset, control_offset, format_offset, divisor_offset:
          s_axi_bresp <= resp_okay;
        default:
          s_axi_bresp <= resp_slverr;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // status and data writes change no flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control <= control_reset;
      format  <= format_reset;
      divisor <= divisor_reset;
    end
    else if (do_write)
    begin
      if (aw_addr == control_offset && w_lanes[0])
        control <= w_low;
      if (aw_addr == format_offset && w_lanes[0])
        format <= w_low;
      if (aw_addr == divisor_offset && w_lanes[0])
        divisor[7:0] <= w_low;
      if (aw_addr == divisor_offset && w_lanes[1])
        divisor[15:8] <= w_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic rd_take;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign pop           = rd_take && s_axi_araddr == data_offset && rx_complete_flag;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= resp_okay;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= resp_okay;
      case (s_axi_araddr)
        data_offset:
          s_axi_rdata <= {24'h00_0000, rx_complete_flag ? buf_data[rd_ptr] : 8'h00};
        status_offset:
          s_axi_rdata <= {24'h00_0000, status_view};
        control_offset:
          s_axi_rdata <= {24'h00_0000, control};
        format_offset:
          s_axi_rdata <= {24'h00_0000, format};
        divisor_offset:
          s_axi_rdata <= {16'h0000, divisor};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= resp_slverr;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_pe_gated_off : assert property (@(posedge aclk) disable iff (!aresetn)
    !parity_check_on |-> !parity_fault_flag)
    else $error("parity fault visible while checking off");

  chk_flush_on_off : assert property (@(posedge aclk) disable iff (!aresetn)
    !receiver_on |=> (count == 2'd0) && !hold_valid && !rx_complete_flag)
    else $error("buffer not flushed on disable");

  chk_pop_advances : assert property (@(posedge aclk) disable iff (!aresetn)
    (receiver_on && pop && !push && count == 2'd1) |=> !rx_complete_flag)
    else $error("data read did not advance buffer");

  chk_ovr_sets : assert property (@(posedge aclk) disable iff (!aresetn)
    (receiver_on && start_seen && count == 2'd2 && hold_valid) ##1 receiver_on
      |-> ovr_pending)
    else $error("overflow not flagged");

  chk_ovr_clears : assert property (@(posedge aclk) disable iff (!aresetn)
    (receiver_on && push) |=> !ovr_pending)
    else $error("overflow not cleared on transfer");

  chk_hold_kept : assert property (@(posedge aclk) disable iff (!aresetn)
    (receiver_on && frame_done && hold_valid && !push) ##1 receiver_on
      |-> hold_valid && $stable(hold_data))
    else $error("waiting frame overwritten on overflow");

  chk_flags_no_write : assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && !push && !pop && receiver_on) |=> $stable(status_view[status_fe_bit]))
    else $error("bus write altered a flag");

  chk_pin_release : assert property (@(posedge aclk) disable iff (!aresetn)
    !receiver_on |-> !rx_pin_claim ##1 (!frame_done && !start_seen))
    else $error("pin claimed or frame kept after disable");

endmodule

// ### sim/serial_tx_model.sv
// Remote serial transmitter that drives the receive line
`timescale 1ns/1ps
module serial_tx_model
(
  // Clock and line
  input  wire logic aclk,
  output logic      rxd
);
  int bit_clks = 32;
  int stop_clks = 32;

  initial rxd = 1'b1;

  task automatic hold_bit(input logic v);
    rxd <= v;
    repeat (bit_clks) @(posedge aclk);
  endtask

  // Mode 0 no parity, 1 even, 2 odd; bad inverts the parity bit
  task automatic send(input logic [7:0] d, input int n, input int mode, input logic bad,
                      input logic stop);
    hold_bit(1'b0);
    for (int i = 0; i < n; i++)
      hold_bit(d[i]);
    if (mode != 0)
      hold_bit(^(d & 8'((1 << n) - 1)) ^ (mode == 2) ^ bad);
    // One stop bit of its own length; a short one pulls the next start early
    rxd <= stop;
    repeat (stop_clks) @(posedge aclk);
  endtask
endmodule

// ### sim/uart_rx_core_bench.sv
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module uart_rx_core_bench
  import uart_rx_pkg::*;
;
  logic        aclk, aresetn, rxd, rx_pin_claim;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          miscompares = 0;
  int          num_checks = 0;

  uart_rx_core u_dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rxd, .rx_pin_claim
  );
  serial_tx_model u_tx
  (
    .aclk, .rxd
  );

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [4:0] a);
    check_data({30'h0, resp}, {30'h0, (a > divisor_offset) ? resp_slverr : resp_okay});
  endtask

  // Ready lines stay high, so a response is taken the edge it shows
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    check_resp(a);
  endtask

  task automatic rd_check(input logic [4:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    resp = s_axi_rresp;
    check_data(s_axi_rdata, exp);
    check_resp(a);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_basic;
    u_tx.send(8'ha5, 8, 0, 1'b0, 1'b1);
    rd_check(status_offset, 32'h80);
    rd_check(data_offset, 32'ha5);
    rd_check(status_offset, 32'h00);
    rd_check(5'h14, 32'h0);
    wr(5'h18, 32'h0);
    wr(format_offset, 32'h00);
    u_tx.send(8'hff, 5, 0, 1'b0, 1'b1);
    rd_check(data_offset, 32'h1f);
    // Two stop bits configured, stop bit driven low, so the frame reads with a stop bit fault
    wr(format_offset, 32'h0e);
    u_tx.send(8'h3c, 8, 0, 1'b0, 1'b0);
    u_tx.hold_bit(1'b1);
    wr(status_offset, 32'h0);
    rd_check(status_offset, 32'h90);
    rd_check(data_offset, 32'h3c);
    // Short stop bit, so the next start edge comes before a full bit ends
    u_tx.stop_clks = 24;
    u_tx.send(8'h81, 8, 0, 1'b0, 1'b1);
    u_tx.stop_clks = 32;
    u_tx.send(8'h7e, 8, 0, 1'b0, 1'b1);
    rd_check(status_offset, 32'h80);
    rd_check(data_offset, 32'h81);
    rd_check(status_offset, 32'h80);
    rd_check(data_offset, 32'h7e);
  endtask

  task automatic t_parity;
    for (int m = 1; m < 3; m++)
      for (int b = 0; b < 2; b++)
      begin
        wr(format_offset, (m == 2) ? 32'h36 : 32'h26);
        u_tx.send(8'h5b, 8, m, b[0], 1'b1);
        rd_check(status_offset, b ? 32'h84 : 32'h80);
        rd_check(data_offset, 32'h5b);
      end
    u_tx.send(8'h5b, 8, 2, 1'b1, 1'b1);
    wr(format_offset, 32'h06);
    rd_check(status_offset, 32'h80);
    rd_check(data_offset, 32'h5b);
    // Seven bits with even parity; top data bit must read zero
    wr(format_offset, 32'h24);
    u_tx.send(8'hd5, 7, 1, 1'b0, 1'b1);
    rd_check(status_offset, 32'h80);
    rd_check(data_offset, 32'h55);
    wr(format_offset, 32'h06);
  endtask

  task automatic t_overrun;
    // Last one is all ones so a dropped frame shows no false start edges
    for (int i = 0; i < 4; i++)
      u_tx.send((i == 3) ? 8'hff : 8'(8'h10 + i), 8, 0, 1'b0, 1'b1);
    u_tx.hold_bit(1'b1);
    rd_check(data_offset, 32'h10);
    rd_check(status_offset, 32'h80);
    rd_check(data_offset, 32'h11);
    rd_check(status_offset, 32'h88);
    rd_check(data_offset, 32'h12);
    rd_check(status_offset, 32'h00);
    u_tx.send(8'h77, 8, 0, 1'b0, 1'b1);
    rd_check(status_offset, 32'h80);
    rd_check(data_offset, 32'h77);
  endtask

  task automatic t_flush;
    int n;
    n = 0;
    u_tx.send(8'h55, 8, 0, 1'b0, 1'b1);
    u_tx.send(8'h66, 8, 0, 1'b0, 1'b1);
    rd_check(status_offset, 32'h80);
    while (s_axi_rdata[status_complete_bit] === 1'b1 && n < 3)
    begin
      rd_check(data_offset, (n == 0) ? 32'h55 : 32'h66);
      n++;
      rd_check(status_offset, (n == 1) ? 32'h80 : 32'h00);
    end
    check_data(32'(n), 32'h2);
  endtask

  task automatic t_disable;
    u_tx.send(8'h42, 8, 0, 1'b0, 1'b1);
    u_tx.send(8'h43, 8, 0, 1'b0, 1'b1);
    wr(control_offset, 32'h0);
    check_data({31'h0, rx_pin_claim}, 32'h0);
    wr(control_offset, 32'h1);
    rd_check(status_offset, 32'h00);
    fork
      u_tx.send(8'h99, 8, 0, 1'b0, 1'b1);
      begin
        repeat (100) @(posedge aclk);
        wr(control_offset, 32'h0);
      end
    join
    wr(control_offset, 32'h1);
    rd_check(status_offset, 32'h00);
  endtask

  task automatic t_start(input logic [7:0] d, input int glitch);
    u_tx.bit_clks = glitch;
    u_tx.hold_bit(1'b0);
    u_tx.bit_clks = (d[0]) ? 16 : 32;
    u_tx.hold_bit(1'b1);
    rd_check(status_offset, 32'h00);
    u_tx.send(d, 8, 0, 1'b0, 1'b1);
    rd_check(data_offset, {24'h0, d});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'h3;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_check(format_offset, 32'h06);
    wr(divisor_offset, 32'h1);
    rd_check(divisor_offset, 32'h1);
    wr(control_offset, 32'h1);
    check_data({31'h0, rx_pin_claim}, 32'h1);
    t_basic();
    t_parity();
    t_overrun();
    t_flush();
    t_disable();
    t_start(8'h24, 14);
    wr(control_offset, 32'h3);
    t_start(8'hc3, 6);
    results();
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    results();
  end
endmodule
